// *** core/cidrs_pkg.sv ***
// Constants for the caller ID ring sequencer.
// Assumes a 200 MHz mclk and an FSK demodulator delivering a mark-idle bit stream.
// How it works
// - Ring input is an active-low square wave at 15.3-68.0 Hz during a burst.
// - After the first burst is recognised, drive the caller ID relay output low.
// - Stay on-hook, no loop current, while caller ID is being received.
// - Each word is one start bit, eight data bits, one stop bit.
// - A message is exactly 21 words, the last being a checksum.
// - Message done and relay released before the second ring burst begins.
// - On answer, close the line hold relay so the line goes off-hook; answer_req is taken only in S_CID or S_WAIT.
// - Decode the message and hand its fields to the host.
package cidrs_pkg;
  localparam int unsigned CLK_KHZ = 200000;
  // Longest ring period (1/15.3 Hz) rounded up; no edge for this long ends a burst
  localparam int unsigned RING_GAP_US = 65360;
  localparam int unsigned RING_GAP_CYC = RING_GAP_US * (CLK_KHZ / 1000);
  // Silence longer than the 4 s off time plus margin means the caller gave up
  localparam int unsigned ABANDON_MS = 8000;
  localparam int unsigned ABANDON_CYC = ABANDON_MS * CLK_KHZ;
  localparam int unsigned BIT_RATE = 1200;
  localparam int unsigned BIT_CYC = (CLK_KHZ * 1000) / BIT_RATE;
  localparam logic [4:0] MSG_WORDS = 5'h15;
  localparam logic [4:0] FIRST_DIGIT_WORD = 5'h03;
  localparam logic [4:0] LAST_DIGIT_WORD = 5'h14;
  localparam int unsigned DIGITS = 18;
  localparam logic [7:0] CALLING_NUMBER_DELIVERY_TYPE = 8'h04;
  localparam logic [7:0] DATA_LEN = 8'h12;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned WORD_W = 8;
  typedef enum {S_IDLE, S_RING1, S_CID, S_WAIT, S_OFF} cidrs_seq_t;
  typedef enum {RX_MARK, RX_IDLE, RX_START, RX_DATA, RX_STOP} cidrs_rx_t;
endpackage

// *** core/cidrs_top.sv ***
// Ring cadence sequencer, caller ID word receiver and its word FIFO.
// Assumes ring_n and fsk_bit are already synchronous to mclk.
`timescale 1ns/1ps

module cidrs_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("cidrs_fifo: DEPTH must be a power of two");
  end
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic full;
    logic nonempty;
  } cidrs_fifo_st_t;
  cidrs_fifo_st_t s_reg, s_next;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;
  assign push = in_valid && !s_reg.full;
  assign pop = out_ready && s_reg.nonempty;
  assign in_ready = !s_reg.full;
  assign out_valid = s_reg.nonempty;
  assign out_data = mem[s_reg.rd];
  always_comb begin
    s_next = s_reg;
    if (push) s_next.wr = s_reg.wr + 1'b1;
    if (pop) s_next.rd = s_reg.rd + 1'b1;
    s_next.cnt = s_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    s_next.full = (s_next.cnt == DEPTH[AW:0]);
    s_next.nonempty = (s_next.cnt != '0);
  end
  always_ff @(posedge clk) begin
    if (rst) s_reg <= '0;
    else s_reg <= s_next;
    if (push) mem[s_reg.wr] <= in_data;
  end
endmodule // cidrs_fifo

module cidrs_top
  import cidrs_pkg::*;
#(
  parameter int unsigned RING_GAP = cidrs_pkg::RING_GAP_CYC,
  parameter int unsigned ABANDON = cidrs_pkg::ABANDON_CYC,
  parameter int unsigned BIT_TIME = cidrs_pkg::BIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Line side
  input wire logic ring_n,
  input wire logic fsk_bit,
  output logic callerid_relay_ctl_n,
  output logic line_hold_relay,
  // Host decisions
  input wire logic answer_req,
  input wire logic hangup_req,
  // Host message stream
  output logic word_valid,
  output logic [cidrs_pkg::WORD_W-1:0] word_data,
  input wire logic word_ready,
  // Decoded message
  output logic msg_done,
  output logic msg_error,
  output logic [4*cidrs_pkg::DIGITS-1:0] cid_digits
);
  import cidrs_pkg::*;
  initial begin
    if (BIT_TIME < 4 || RING_GAP < 2 || ABANDON <= RING_GAP) $error("cidrs_top: bad timing parameters");
  end

  typedef struct packed {
    cidrs_seq_t st;
    cidrs_rx_t rx;
    logic [31:0] ring_cnt;
    logic ring_prev;
    logic [31:0] bit_cnt;
    logic [3:0] bit_idx;
    logic [7:0] shreg;
    logic [4:0] word_idx;
    logic [7:0] sum;
    logic hdr_ok;
    logic err;
    logic [4*DIGITS-1:0] digits;
    logic relay_n;
    logic hold;
    logic done;
    logic push;
    logic [7:0] push_data;
  } cidrs_st_t;
  cidrs_st_t r_reg, r_next;
  logic fifo_ready;
  logic ring_fall;
  logic word_end;

  assign ring_fall = r_reg.ring_prev && !ring_n;
  assign callerid_relay_ctl_n = r_reg.relay_n;
  assign line_hold_relay = r_reg.hold;
  assign msg_done = r_reg.done;
  assign msg_error = r_reg.err;
  assign cid_digits = r_reg.digits;
  assign word_end = (r_reg.rx == RX_STOP) && (r_reg.bit_cnt == '0);

  always_comb begin
    r_next = r_reg;
    r_next.ring_prev = ring_n;
    r_next.done = 1'b0;
    r_next.push = 1'b0;
    // Saturating count of cycles since the last falling ring edge
    if (ring_fall) r_next.ring_cnt = '0;
    else if (r_reg.ring_cnt < ABANDON) r_next.ring_cnt = r_reg.ring_cnt + 32'h1;
    if (r_reg.bit_cnt != '0) r_next.bit_cnt = r_reg.bit_cnt - 32'h1;
    // Word receiver, live only while the relay couples the line
    if (r_reg.st == S_CID) begin
      case (r_reg.rx)
        RX_MARK: begin
          // One mark bit time first, so the carrier preamble never looks like a start bit
          if (!fsk_bit) r_next.bit_cnt = BIT_TIME;
          else if (r_reg.bit_cnt == '0) r_next.rx = RX_IDLE;
        end
        RX_IDLE: begin
          if (!fsk_bit) begin
            r_next.rx = RX_START;
            r_next.bit_cnt = BIT_TIME / 2;
          end
        end
        RX_START: begin
          if (r_reg.bit_cnt == '0) begin
            if (fsk_bit) r_next.rx = RX_IDLE;
            else begin
              // Reload one short: the sample edge itself is a cycle of the bit
              r_next.rx = RX_DATA;
              r_next.bit_cnt = BIT_TIME - 32'h1;
              r_next.bit_idx = 4'h0;
            end
          end
        end
        RX_DATA: begin
          if (r_reg.bit_cnt == '0) begin
            r_next.shreg = {fsk_bit, r_reg.shreg[7:1]};
            r_next.bit_cnt = BIT_TIME - 32'h1;
            r_next.bit_idx = r_reg.bit_idx + 4'h1;
            if (r_reg.bit_idx == 4'h7) r_next.rx = RX_STOP;
          end
        end
        RX_STOP: begin
          if (r_reg.bit_cnt == '0) begin
            r_next.rx = RX_IDLE;
            if (!fsk_bit) r_next.err = 1'b1;
            r_next.word_idx = r_reg.word_idx + 5'h1;
            r_next.sum = r_reg.sum + r_reg.shreg;
            // Host cannot stall the line; a word refused by a full FIFO marks the message bad
            if (fifo_ready) begin
              r_next.push = 1'b1;
              r_next.push_data = r_reg.shreg;
            end else r_next.err = 1'b1;
            if (r_reg.word_idx == 5'h0 && r_reg.shreg != CALLING_NUMBER_DELIVERY_TYPE) r_next.hdr_ok = 1'b0;
            if (r_reg.word_idx == 5'h1 && r_reg.shreg != DATA_LEN) r_next.hdr_ok = 1'b0;
            if (r_next.word_idx >= FIRST_DIGIT_WORD && r_next.word_idx <= LAST_DIGIT_WORD) begin
              r_next.digits = {r_reg.digits[4*DIGITS-5:0], r_reg.shreg[3:0]};
            end
          end
        end
        default: r_next.rx = RX_MARK;
      endcase
    end
    // Ring cadence sequencing
    case (r_reg.st)
      S_IDLE: begin
        if (ring_fall) r_next.st = S_RING1;
      end
      S_RING1: begin
        if (r_reg.ring_cnt >= RING_GAP) begin
          r_next.st = S_CID;
          r_next.relay_n = 1'b0;
          r_next.rx = RX_MARK;
          r_next.bit_cnt = BIT_TIME;
          r_next.word_idx = 5'h0;
          r_next.sum = 8'h00;
          r_next.hdr_ok = 1'b1;
          r_next.err = 1'b0;
          r_next.digits = '0;
        end
      end
      S_CID: begin
        if (word_end && r_reg.word_idx == MSG_WORDS - 5'h1) begin
          r_next.st = S_WAIT;
          r_next.relay_n = 1'b1;
          r_next.done = 1'b1;
          if ((r_reg.sum + r_reg.shreg) != 8'h00 || !r_next.hdr_ok) r_next.err = 1'b1;
        end else if (ring_fall) begin
          // Second burst arrived first: open the path at once to spare the receiver
          r_next.st = S_WAIT;
          r_next.relay_n = 1'b1;
          r_next.err = 1'b1;
          r_next.done = 1'b1;
        end
      end
      S_WAIT: begin
        if (r_reg.ring_cnt >= ABANDON) r_next.st = S_IDLE;
      end
      S_OFF: begin
        if (hangup_req) begin
          r_next.st = S_IDLE;
          r_next.hold = 1'b0;
        end
      end
      default: r_next.st = S_IDLE;
    endcase
    // Answer wins over everything once caller ID reception has begun (S_CID or S_WAIT)
    if (answer_req && (r_reg.st == S_CID || r_reg.st == S_WAIT)) begin
      r_next.st = S_OFF;
      r_next.relay_n = 1'b1;
      r_next.hold = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      r_reg <= '0;
      r_reg.st <= S_IDLE;
      r_reg.rx <= RX_MARK;
      r_reg.relay_n <= 1'b1;
      r_reg.ring_prev <= 1'b1;
      r_reg.hdr_ok <= 1'b1;
    end else r_reg <= r_next;
  end

  cidrs_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(mclk),
    .rst(reset),
    .in_valid(r_reg.push),
    .in_data(r_reg.push_data),
    .in_ready(fifo_ready),
    .out_valid(word_valid),
    .out_data(word_data),
    .out_ready(word_ready)
  );

  ring_start_a: assert property (@(posedge mclk) disable iff (reset)
    r_reg.st == S_IDLE && ring_fall |=> r_reg.st == S_RING1) else $error("first ring edge not taken");
  relay_close_a: assert property (@(posedge mclk) disable iff (reset)
    r_reg.st == S_RING1 && r_reg.ring_cnt >= RING_GAP |=> !callerid_relay_ctl_n && r_reg.st == S_CID)
    else $error("relay not closed after first burst");
  onhook_hold_a: assert property (@(posedge mclk) disable iff (reset)
    !(!callerid_relay_ctl_n && line_hold_relay)) else $error("loop current while coupling caller id");
  word_count_a: assert property (@(posedge mclk) disable iff (reset)
    msg_done && !msg_error |-> r_reg.word_idx == MSG_WORDS) else $error("clean message not 21 words");
  header_ok_a: assert property (@(posedge mclk) disable iff (reset)
    msg_done && !msg_error |-> r_reg.hdr_ok) else $error("bad header accepted");
  second_ring_a: assert property (@(posedge mclk) disable iff (reset)
    r_reg.st == S_CID && ring_fall |=> callerid_relay_ctl_n ##1 callerid_relay_ctl_n)
    else $error("relay held into second burst");
  answer_hook_a: assert property (@(posedge mclk) disable iff (reset)
    answer_req && r_reg.st inside {S_CID, S_WAIT} |=> line_hold_relay && r_reg.st == S_OFF)
    else $error("answer did not seize line");
  word_push_a: assert property (@(posedge mclk) disable iff (reset)
    word_end && fifo_ready && r_reg.st == S_CID |=> r_reg.push && r_reg.push_data == $past(r_reg.shreg))
    else $error("received word not handed over");
  digit_shift_a: assert property (@(posedge mclk) disable iff (reset)
    word_end && r_reg.st == S_CID && r_reg.word_idx >= 5'h2 && r_reg.word_idx <= 5'h13
    |=> cid_digits[3:0] == $past(r_reg.shreg[3:0])) else $error("digit not captured");
  checksum_a: assert property (@(posedge mclk) disable iff (reset)
    msg_done && r_reg.word_idx == MSG_WORDS && r_reg.sum != 8'h00 |-> msg_error)
    else $error("bad checksum not flagged");
endmodule // cidrs_top

// *** test/cidrs_office_model.sv ***
// Central office stand-in: ring bursts and FSK caller ID words.
// Assumes the bench calls its tasks; drives at the falling edge.
`timescale 1ns/1ps

module cidrs_office_model #(
  parameter int unsigned BIT_TIME = 8
) (
  // Clock
  input wire logic mclk,
  // Line
  output logic ring_n,
  output logic fsk_bit
);
  initial begin
    ring_n = 1'b1;
    fsk_bit = 1'b1;
  end

  // Square wave, four cycles low and four high
  task automatic ring(input int pulses);
    repeat (pulses) begin
      @(negedge mclk) ring_n = 1'b0;
      repeat (4) @(negedge mclk);
      ring_n = 1'b1;
      repeat (3) @(negedge mclk);
    end
  endtask

  // Seizure toggles faster than a bit, so it never passes for mark
  task automatic preamble();
    repeat (BIT_TIME * 3) @(negedge mclk) fsk_bit = ~fsk_bit;
    @(negedge mclk) fsk_bit = 1'b1;
    repeat (BIT_TIME * 2) @(negedge mclk);
  endtask

  task automatic send_word(input logic [7:0] w);
    logic [9:0] f;
    f = {1'b1, w, 1'b0};
    for (int i = 0; i < 10; i++) begin
      fsk_bit = f[i];
      repeat (BIT_TIME) @(negedge mclk);
    end
  endtask
endmodule // cidrs_office_model

// *** test/caller_id_ring_sequencer_tb_top.sv ***
// Bench for the caller ID ring sequencer with short counts.
// Assumes cidrs_pkg and the office model are compiled first.
`timescale 1ns/1ps

module caller_id_ring_sequencer_tb_top;
  import cidrs_pkg::*;
  localparam int unsigned RG = 50;
  localparam int unsigned BT = 8;
  logic mclk, reset, ring_n, fsk_bit, relay_n, hold, answer_req, hangup_req;
  logic word_valid, word_ready, msg_done, msg_error;
  logic [7:0] word_data;
  logic [71:0] cid_digits, exp_dig;
  logic [7:0] exp_q[$];
  int n_errors, tests_run, n_done;

  cidrs_top #(.RING_GAP(RG), .ABANDON(400), .BIT_TIME(BT)) cidrs_top_i (.mclk(mclk), .reset(reset),
    .ring_n(ring_n), .fsk_bit(fsk_bit), .callerid_relay_ctl_n(relay_n), .line_hold_relay(hold),
    .answer_req(answer_req), .hangup_req(hangup_req), .word_valid(word_valid), .word_data(word_data),
    .word_ready(word_ready), .msg_done(msg_done), .msg_error(msg_error), .cid_digits(cid_digits));
  cidrs_office_model #(.BIT_TIME(BT)) cidrs_office_model_i (.mclk(mclk), .ring_n(ring_n), .fsk_bit(fsk_bit));

  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Done is a one-cycle pulse, so count it here
  always @(negedge mclk) begin
    if (msg_done === 1'b1) begin
      n_done++;
    end
  end

  task automatic wait_relay(input logic lvl, input int lim);
    int k;
    k = 0;
    while (relay_n !== lvl && k < lim) begin
      @(negedge mclk);
      k++;
    end
    check("relay_n", relay_n, lvl);
  endtask

  // One call; cut > 0 rings again after that many words
  task automatic call(input int bad, input int cut);
    logic [7:0] w[21];
    logic [7:0] sum;
    int d;
    d = n_done;
    sum = 8'h00;
    w[0] = CALLING_NUMBER_DELIVERY_TYPE;
    w[1] = DATA_LEN;
    for (int i = 0; i < 20; i++) begin
      if (i > 1) begin
        w[i] = 8'($urandom % 10);
        exp_dig[79 - 4 * i -: 4] = w[i][3:0];
      end
      sum = sum + w[i];
    end
    w[20] = 8'h00 - sum + 8'(bad);
    cidrs_office_model_i.ring(3);
    check("relay_n", relay_n, 1'b1);
    wait_relay(1'b0, RG + 10);
    check("hold", hold, 1'b0);
    cidrs_office_model_i.preamble();
    for (int i = 0; i < ((cut > 0) ? cut : 21); i++) begin
      cidrs_office_model_i.send_word(w[i]);
      if (exp_q.size() < 32) begin
        exp_q.push_back(w[i]);
      end
    end
    if (cut > 0) begin
      cidrs_office_model_i.ring(1);
    end
    repeat (4) @(negedge mclk);
    check("relay_n", relay_n, 1'b1);
    check("done", 72'(n_done - d), 72'(1));
  endtask

  // Host stalls at random while draining
  task automatic drain(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 4000) begin
      word_ready = 1'(($urandom % 3) != 0);
      // Valid and data stand from one rising edge to the next; take them at the falling edge
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
        check("word", word_data, exp_q.pop_front());
        n--;
      end
      @(negedge mclk);
      k++;
    end
    word_ready = 1'b0;
    check("drained", 72'(n), 72'(0));
    repeat (3) @(negedge mclk);
    check("empty", word_valid, 1'b0);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    #100000;
    n_errors++;
    stop_test();
  end

  initial begin
    reset = 1'b1;
    answer_req = 1'b0;
    hangup_req = 1'b0;
    word_ready = 1'b0;
    void'($urandom(32'h4A7FC3C0));
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    call(0, 0);
    check("error", msg_error, 1'b0);
    check("digits", cid_digits, exp_dig);
    repeat (450) @(negedge mclk);
    // Second message overflows the undrained buffer
    call(0, 0);
    check("error", msg_error, 1'b1);
    drain(exp_q.size());
    repeat (450) @(negedge mclk);
    call(1, 0);
    check("error", msg_error, 1'b1);
    check("digits", cid_digits, exp_dig);
    drain(exp_q.size());
    repeat (450) @(negedge mclk);
    call(0, 5);
    check("error", msg_error, 1'b1);
    drain(exp_q.size());
    answer_req = 1'b1;
    @(negedge mclk);
    answer_req = 1'b0;
    @(negedge mclk);
    check("hold", hold, 1'b1);
    check("relay_n", relay_n, 1'b1);
    hangup_req = 1'b1;
    @(negedge mclk);
    hangup_req = 1'b0;
    @(negedge mclk);
    check("hold", hold, 1'b0);
    stop_test();
  end
endmodule // caller_id_ring_sequencer_tb_top
